// ===== verilog/adc_port_pkg.sv
// Constants and types for the serial converter control port
// Behaviour
// - A falling chip select clears counters and control state and opens the serial pins.
// - A rising chip select stops the block from taking serial data or clock edges.
// - The first four rising clock edges shift in a command nibble, first input bit first.
// - The next four rising edges shift in four configuration bits, eight bits in all.
// - The channel address takes effect once the fourth rising edge has passed.
// - The result output floats while chip select is high and is driven while low.
// - On selection the first result bit, MSB or LSB per bit order, is driven at once.
// - Each later falling clock edge drives the next of the remaining 11 result bits.
// - Sampling starts at the fourth falling edge and lasts to the frame's last one.
// - At the last falling edge the conversion passes to the internal controller.
// - The end-of-conversion flag goes low after the frame's last falling edge.
// - The flag stays low until the result is ready, then returns high.
package adc_port_pkg;

    //--------------------------------------------------------------
    // Frame geometry
    //--------------------------------------------------------------
    localparam int unsigned RESULT_BITS    = 12;
    localparam int unsigned NIBBLE_BITS    = 4;
    localparam int unsigned CONFIG_BITS    = 4;
    localparam logic [4:0]  ADDR_EDGE      = 5'h04;
    localparam logic [4:0]  SAMPLE_EDGE    = 5'h04;
    localparam logic [4:0]  LAST_FALL_EDGE = 5'h0C;
    localparam logic [4:0]  INPUT_EDGES    = 5'h08;

    //--------------------------------------------------------------
    // Conversion timing
    //--------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS  = 4000;
    localparam int unsigned CONV_TIME_NS   = 2000;
    localparam int unsigned CONV_CYCLES    =
        (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [9:0]  CONV_CYCLES_W  = CONV_CYCLES[9:0];

    //--------------------------------------------------------------
    // Reset values and configuration bit index
    //--------------------------------------------------------------
    localparam logic [11:0] RESULT_RESET   = 12'h0000;
    localparam logic [3:0]  NIBBLE_RESET   = 4'h0;
    localparam logic [3:0]  CONFIG_RESET   = 4'h0;
    localparam int unsigned CFG_LSB_FIRST  = 1;

    typedef enum logic [1:0] {
        IDLE_ST    = 2'b00,
        FRAME_ST   = 2'b01,
        CONVERT_ST = 2'b10
    } conv_state_type;

endpackage : adc_port_pkg

// ===== verilog/sar_engine.sv
// Internal conversion controller that runs on the block clock alone
`timescale 1ns/1ps
`default_nettype none
module sar_engine (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        start,
    input  wire logic [11:0] sampleIn,
    output logic             busy,
    output logic             done,
    output logic [11:0]      result
);
    logic [9:0] cntReg;

    //--------------------------------------------------------------
    // Conversion timer
    //--------------------------------------------------------------
    // Fixed conversion length, independent of the serial clock
    always_ff @(posedge ref_clk) begin
        done <= 1'b0;
        if (!rst_b) begin
            cntReg <= 10'h000;
            busy   <= 1'b0;
            result <= adc_port_pkg::RESULT_RESET;
        end else if (start) begin
            cntReg <= adc_port_pkg::CONV_CYCLES_W;
            busy   <= 1'b1;
        end else if (busy) begin
            if (cntReg == 10'h001) begin
                busy   <= 1'b0;
                done   <= 1'b1;
                result <= sampleIn;
            end
            cntReg <= cntReg - 10'h001;
        end
    end
endmodule : sar_engine
`default_nettype wire

// ===== verilog/serial_adc_port_control.sv
// Serial command and result port of the multi-channel converter
`timescale 1ns/1ps
`default_nettype none
module serial_adc_port_control (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        chipSel_b,
    input  wire logic        serClk,
    input  wire logic        serDataIn,
    input  wire logic [11:0] analogCode,
    output logic             serDataOut,
    output logic             serDataOutEn_b,
    output logic             convDone,
    output logic [3:0]       channelAddr,
    output logic             sampling,
    output logic [3:0]       configBits
);

    //--------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------
    logic [1:0] csSync;
    logic [1:0] clkSync;
    logic [1:0] dinSync;
    logic       csPrev;
    logic       clkPrev;

    // Two flops each; only the second flop feeds logic
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            csSync  <= 2'b11;
            clkSync <= 2'b00;
            dinSync <= 2'b00;
            csPrev  <= 1'b1;
            clkPrev <= 1'b0;
        end else begin
            csSync  <= {csSync[0], chipSel_b};
            clkSync <= {clkSync[0], serClk};
            dinSync <= {dinSync[0], serDataIn};
            csPrev  <= csSync[1];
            clkPrev <= clkSync[1];
        end
    end

    logic csFall;
    logic csRise;
    logic selected;
    logic sclkRise;
    logic sclkFall;
    assign csFall   = csPrev & ~csSync[1];
    assign csRise   = ~csPrev & csSync[1];
    assign selected = ~csSync[1];
    // Clock edges ignored while deselected
    assign sclkRise = selected & ~clkPrev & clkSync[1];
    assign sclkFall = selected & clkPrev & ~clkSync[1];

    //--------------------------------------------------------------
    // Edge counters
    //--------------------------------------------------------------
    logic [4:0] riseCnt_reg;
    logic [4:0] fallCnt_reg;

    // Cleared by selection so a torn frame cannot leak into the next
    always_ff @(posedge ref_clk) begin
        if (!rst_b || csFall) begin
            riseCnt_reg <= 5'h00;
            fallCnt_reg <= 5'h00;
        end else begin
            if (sclkRise && riseCnt_reg != 5'h1F)
                riseCnt_reg <= riseCnt_reg + 5'h01;
            if (sclkFall && fallCnt_reg != 5'h1F)
                fallCnt_reg <= fallCnt_reg + 5'h01;
        end
    end

    //--------------------------------------------------------------
    // Input shift: command nibble then configuration
    //--------------------------------------------------------------
    logic [3:0] command_nibble_reg;
    logic [3:0] cfgShift_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            command_nibble_reg <= adc_port_pkg::NIBBLE_RESET;
            cfgShift_reg       <= adc_port_pkg::CONFIG_RESET;
        end else if (csFall) begin
            command_nibble_reg <= adc_port_pkg::NIBBLE_RESET;
        end else if (sclkRise) begin
            // first_input_bit arrives first and ends in the top bit
            if (riseCnt_reg < adc_port_pkg::ADDR_EDGE)
                command_nibble_reg <= {command_nibble_reg[2:0],
                                       dinSync[1]};
            else if (riseCnt_reg < adc_port_pkg::INPUT_EDGES)
                cfgShift_reg <= {cfgShift_reg[2:0], dinSync[1]};
        end
    end

    // Address published only after the fourth rising edge
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            channelAddr <= adc_port_pkg::NIBBLE_RESET;
            configBits  <= adc_port_pkg::CONFIG_RESET;
        end else begin
            if (riseCnt_reg == adc_port_pkg::ADDR_EDGE)
                channelAddr <= command_nibble_reg;
            if (riseCnt_reg == adc_port_pkg::INPUT_EDGES)
                configBits <= cfgShift_reg;
        end
    end

    //--------------------------------------------------------------
    // Frame state and conversion hand-off
    //--------------------------------------------------------------
    adc_port_pkg::conv_state_type state_reg;
    logic           engBusy;
    logic           engDone;
    logic [11:0]    engResult;
    logic           startConv;
    logic           lastFall;

    assign lastFall  = sclkFall &&
        (fallCnt_reg == adc_port_pkg::LAST_FALL_EDGE - 5'h01);
    assign startConv = lastFall &&
        state_reg == adc_port_pkg::FRAME_ST;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_reg <= adc_port_pkg::IDLE_ST;
        end else begin
            case (state_reg)
                adc_port_pkg::IDLE_ST: begin
                    if (csFall)
                        state_reg <= adc_port_pkg::FRAME_ST;
                end
                adc_port_pkg::FRAME_ST: begin
                    if (startConv)
                        state_reg <= adc_port_pkg::CONVERT_ST;
                    else if (csRise)
                        state_reg <= adc_port_pkg::IDLE_ST;
                end
                adc_port_pkg::CONVERT_ST: begin
                    if (engDone)
                        state_reg <= adc_port_pkg::IDLE_ST;
                end
                default: state_reg <= adc_port_pkg::IDLE_ST;
            endcase
        end
    end

    sar_engine u_engine (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .start    (startConv),
        .sampleIn (analogCode),
        .busy     (engBusy),
        .done     (engDone),
        .result   (engResult)
    );

    // Sample window from fourth falling edge to the last one
    always_ff @(posedge ref_clk) begin
        if (!rst_b || csFall || startConv || csRise)
            sampling <= 1'b0;
        else if (sclkFall &&
                 fallCnt_reg == adc_port_pkg::SAMPLE_EDGE - 5'h01)
            sampling <= 1'b1;
    end

    // Low from frame end until the result is latched
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            convDone <= 1'b1;
        else if (startConv)
            convDone <= 1'b0;
        else if (engDone)
            convDone <= 1'b1;
    end

    //--------------------------------------------------------------
    // Result output shifter
    //--------------------------------------------------------------
    logic [11:0] outShift_reg;
    logic        lsbFirst;
    assign lsbFirst = configBits[adc_port_pkg::CFG_LSB_FIRST];

    // Bit order chosen from the last frame's configuration
    function automatic logic [11:0] orderBits(input logic [11:0] v,
                                              input logic lsb);
        logic [11:0] r;
        r = v;
        if (lsb)
            r = {<<{v}};
        return r;
    endfunction : orderBits

    // Result in send order; a function result cannot be bit-selected
    logic [11:0] firstWord;
    assign firstWord = orderBits(engResult, lsbFirst);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            outShift_reg <= adc_port_pkg::RESULT_RESET;
            serDataOut   <= 1'b0;
        end else if (csFall) begin
            outShift_reg <= firstWord;
            serDataOut   <= firstWord[11];
        end else if (sclkFall &&
                     fallCnt_reg < adc_port_pkg::LAST_FALL_EDGE - 5'h01) begin
            outShift_reg <= {outShift_reg[10:0], 1'b0};
            serDataOut   <= outShift_reg[10];
        end
    end

    // Enable follows the synchronised select level
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            serDataOutEn_b <= 1'b1;
        else
            serDataOutEn_b <= csSync[1];
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    chk_out_float: assert property (@(posedge ref_clk) disable iff (!rst_b)
        csSync[1] |=> serDataOutEn_b)
        else $error("output driven while deselected");
    chk_out_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !csSync[1] |=> !serDataOutEn_b)
        else $error("output floating while selected");
    chk_first_bit: assert property (@(posedge ref_clk) disable iff (!rst_b)
        csFall |=> serDataOut == outShift_reg[11])
        else $error("first result bit wrong");
    chk_shift_next: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (sclkFall && !csFall && fallCnt_reg < 5'h0B)
        |=> serDataOut == $past(outShift_reg[10]))
        else $error("result bit not advanced");
    chk_eoc_fall: assert property (@(posedge ref_clk) disable iff (!rst_b)
        startConv |=> !convDone)
        else $error("flag did not fall");
    chk_eoc_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
        startConv |=> !convDone [*8])
        else $error("flag rose too early");
    chk_eoc_rise: assert property (@(posedge ref_clk) disable iff (!rst_b)
        engDone |=> convDone)
        else $error("flag not restored");
    chk_addr_late: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (riseCnt_reg == 5'h04) |=> channelAddr == $past(command_nibble_reg))
        else $error("address not applied");
    chk_sample_win: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (sclkFall && fallCnt_reg == 5'h03 && !csFall) |=> sampling)
        else $error("sampling not started");
    chk_cnt_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
        csFall |=> riseCnt_reg == 5'h00 && fallCnt_reg == 5'h00)
        else $error("counters not cleared");
    chk_deselect: assert property (@(posedge ref_clk) disable iff (!rst_b)
        csSync[1] && !csRise |=> $stable(riseCnt_reg))
        else $error("edge counted while deselected");

    chk_cmd_shift: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (sclkRise && !csFall && riseCnt_reg < 5'h04)
        |=> command_nibble_reg[0] == $past(dinSync[1]))
        else $error("command bit not shifted in");
    chk_cfg_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (riseCnt_reg == 5'h08) |=> configBits == $past(cfgShift_reg))
        else $error("configuration not applied");
    chk_conv_start: assert property (@(posedge ref_clk) disable iff (!rst_b)
        startConv |=> engBusy && !sampling)
        else $error("conversion not handed off");

    cov_frame: cover property (@(posedge ref_clk) startConv);
    cov_done: cover property (@(posedge ref_clk) engDone);
    cov_lsb: cover property (@(posedge ref_clk) csFall && lsbFirst);
    cov_abort: cover property (@(posedge ref_clk)
        csRise && state_reg == adc_port_pkg::FRAME_ST);
endmodule : serial_adc_port_control
`default_nettype wire

// ===== testbench/host_port_model.sv
// Behavioural host serial controller driving the converter link
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
    input  wire logic       ref_clk,
    output logic            chipSel_b,
    output logic            serClk,
    output logic            serDataIn,
    input  wire logic       serDataOut,
    input  wire logic       serDataOutEn_b,
    input  wire logic       sampling,
    input  wire logic [3:0] channelAddr
);
    // Half of an 80 ns link period at 4 ns per block clock
    localparam int HALF = 10;

    logic inFrame;
    logic txBit;

    initial begin
        chipSel_b = 1'b1;
        serClk    = 1'b0;
        serDataIn = 1'b0;
        inFrame   = 1'b0;
        txBit     = 1'b0;
    end

    // Data line toggles outside frames so a stale bit is never trusted
    always @(posedge ref_clk) begin
        serDataIn <= inFrame ? txBit : ~serDataIn;
    end

    //------------------------------------------------------------------
    // Frame: select, nBits clocks (rise then fall), deselect
    //------------------------------------------------------------------
    task automatic frame(input logic [7:0] tx, input int nBits,
                         output logic [11:0] rx, output logic [11:0] samp,
                         output logic [3:0] addr4);
        rx    = '0;
        samp  = '0;
        addr4 = '0;
        @(posedge ref_clk);
        chipSel_b <= 1'b0;
        inFrame   <= 1'b1;
        for (int i = 0; i < nBits; i++) begin
            // Command bits first input bit first, then configuration
            txBit <= (i < 8) ? tx[7 - i] : ~txBit;
            repeat (HALF) @(posedge ref_clk);
            // Released output reads inverted, so an enable fault shows up
            rx[11 - i] = serDataOutEn_b ? ~serDataOut : serDataOut;
            samp[i]    = sampling;
            if (i == 4) begin
                addr4 = channelAddr;
            end
            serClk <= 1'b1;
            repeat (HALF) @(posedge ref_clk);
            serClk <= 1'b0;
        end
        repeat (HALF) @(posedge ref_clk);
        chipSel_b <= 1'b1;
        inFrame   <= 1'b0;
        // Let the select rise pass the synchroniser and enable flop
        repeat (4) @(posedge ref_clk);
    endtask : frame

    // Clock pulses with the chip deselected, which must be ignored
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (HALF) @(posedge ref_clk);
            serClk <= 1'b1;
            repeat (HALF) @(posedge ref_clk);
            serClk <= 1'b0;
        end
    endtask : idle_clocks
endmodule : host_port_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the serial converter control port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        ref_clk = 1'b0;
    logic        rst_b;
    logic [11:0] analogCode;
    wire  logic  chipSel_b, serClk, serDataIn;
    logic        serDataOut, serDataOutEn_b, convDone, sampling;
    logic [3:0]  channelAddr, configBits;
    int          failures = 0;
    int          totalChecks = 0;
    logic [11:0] rx, samp;
    logic [3:0]  addr4;

    always #2 ref_clk = ~ref_clk;

    serial_adc_port_control u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .chipSel_b(chipSel_b), .serClk(serClk), .serDataIn(serDataIn),
        .analogCode(analogCode), .serDataOut(serDataOut),
        .serDataOutEn_b(serDataOutEn_b), .convDone(convDone),
        .channelAddr(channelAddr), .sampling(sampling),
        .configBits(configBits));

    host_port_model u_host (.ref_clk(ref_clk), .chipSel_b(chipSel_b),
        .serClk(serClk), .serDataIn(serDataIn), .serDataOut(serDataOut),
        .serDataOutEn_b(serDataOutEn_b), .sampling(sampling),
        .channelAddr(channelAddr));

    //------------------------------------------------------------------
    // Shared helpers
    //------------------------------------------------------------------
    task automatic check(input string name, input logic [11:0] seen,
                         input logic [11:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [11:0] reverse12(input logic [11:0] v);
        for (int i = 0; i < 12; i++) reverse12[i] = v[11 - i];
    endfunction : reverse12

    // Full frame; the code is what the next conversion will capture
    task automatic do_frame(input logic [3:0] cmd, input logic [3:0] cfg,
                            input logic [11:0] code);
        @(posedge ref_clk);
        analogCode <= code;
        u_host.frame({cmd, cfg}, 12, rx, samp, addr4);
        check("enable after frame", {11'h000, serDataOutEn_b}, 12'h001);
        check("flag low after frame", {11'h000, convDone}, 12'h000);
        check("sample window", samp, 12'hFF0);
        check("address after 4 rises", {8'h00, addr4}, {8'h00, cmd});
        check("channel address", {8'h00, channelAddr}, {8'h00, cmd});
        check("config bits", {8'h00, configBits}, {8'h00, cfg});
    endtask : do_frame

    // Conversion handed off, flag held low about 500 cycles
    task automatic wait_done();
        int cnt;
        cnt = 0;
        while (convDone !== 1'b1 && cnt < 2000) begin
            @(posedge ref_clk);
            cnt++;
        end
        check("conversion time ok", {11'h000, (cnt >= 485 && cnt <= 500)},
              12'h001);
    endtask : wait_done

    //------------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------------
    task automatic test_reset();
        check("enable at reset", {11'h000, serDataOutEn_b}, 12'h001);
        check("flag at reset", {11'h000, convDone}, 12'h001);
        check("sampling at reset", {11'h000, sampling}, 12'h000);
        check("address at reset", {8'h00, channelAddr}, 12'h000);
        check("config at reset", {8'h00, configBits}, 12'h000);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_first_frame();
        do_frame(4'hA, 4'h0, 12'h5A3);
        check("first readout", rx, 12'h000);
        wait_done();
        $display("test_first_frame done");
    endtask : test_first_frame

    task automatic test_msb_readback();
        do_frame(4'h3, 4'h2, 12'hC35);
        check("msb first readout", rx, 12'h5A3);
        wait_done();
        $display("test_msb_readback done");
    endtask : test_msb_readback

    task automatic test_lsb_readback();
        do_frame(4'hF, 4'h0, 12'h0FF);
        check("lsb first readout", rx, reverse12(12'hC35));
        wait_done();
        $display("test_lsb_readback done");
    endtask : test_lsb_readback

    // Short frame, then clocks while deselected, then a clean frame
    task automatic test_abort();
        u_host.frame(8'h96, 2, rx, samp, addr4);
        check("no conversion on abort", {11'h000, convDone}, 12'h001);
        check("float after abort", {11'h000, serDataOutEn_b}, 12'h001);
        u_host.idle_clocks(6);
        check("address kept", {8'h00, channelAddr}, 12'h00F);
        check("flag kept", {11'h000, convDone}, 12'h001);
        do_frame(4'h1, 4'h0, 12'h321);
        check("readout after abort", rx, 12'h0FF);
        wait_done();
        $display("test_abort done");
    endtask : test_abort

    //------------------------------------------------------------------
    // Run control
    //------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // Five frames and four conversions need about 3200 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        $display("MISMATCH watchdog expected finish seen timeout");
        final_report();
    end

    initial begin
        rst_b      = 1'b0;
        analogCode = 12'h000;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        test_reset();
        test_first_frame();
        test_msb_readback();
        test_lsb_readback();
        test_abort();
        final_report();
    end
endmodule : testbench
`default_nettype wire
